// File: psi_ctrl.sv
// psi_ctrl: power-state secondary interrupt group with apb register access.
// assumes event inputs synchronous to sys_clk and a well-behaved apb master.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module psi_ctrl
  import psi_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // power-state event sources
  input  wire logic              por_event,
  input  wire logic              enter_low_event,
  input  wire logic              enter_active_event,
  // other primary sources, levels
  input  wire logic              high_current_src,
  input  wire logic              undervoltage_src,
  // interrupt outputs
  output logic                   power_state_primary_irq,
  output logic                   high_current_irq,
  output logic                   undervoltage_irq,
  output logic                   irq
);

  logic [2:0]  ev_ff;
  logic [2:0]  ev_prev_ff;
  logic [2:0]  rise;
  logic [2:0]  stat_ff;
  logic [2:0]  nxt_stat;
  logic [2:0]  mask_ff;
  logic [1:0]  prim_mask_ff;
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        ps_irq_ff;
  logic        hc_irq_ff;
  logic        uv_irq_ff;
  logic        irq_ff;
  logic        acc;
  logic        wr_en;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_prim;
  logic        hit_any;
  logic        wr_stat;
  logic        pend;
  logic [15:0] idx;
  logic        aligned;

  // register address decode
  assign idx      = paddr[17:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign hit_stat = aligned && (idx == PSI_STAT_IDX);
  assign hit_mask = aligned && (idx == PSI_MASK_IDX);
  assign hit_prim = aligned && (idx == PSI_PRIM_MASK_IDX);
  assign hit_any  = hit_stat || hit_mask || hit_prim;
  // access phase, answered one cycle after it opens
  assign acc      = psel && penable && !pready_ff;
  assign wr_en    = psel && penable && pready_ff && pwrite;
  assign wr_stat  = wr_en && hit_stat;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_ff      <= 3'h0;
      ev_prev_ff <= 3'h0;
    end else begin
      ev_ff[PSI_BIT_POR]    <= por_event;
      ev_ff[PSI_BIT_LOW]    <= enter_low_event;
      ev_ff[PSI_BIT_ACTIVE] <= enter_active_event;
      ev_prev_ff            <= ev_ff;
    end
  end

  assign rise = ev_ff & ~ev_prev_ff;

  // status next value; a new edge wins over a same-cycle clear
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & ~pwdata[2:0];
    end
    nxt_stat = nxt_stat | rise;
  end

  // status register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= PSI_STAT_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_ff      <= PSI_MASK_RST;
      prim_mask_ff <= PSI_PRIM_MASK_RST;
    end else begin
      if (wr_en && hit_mask) begin
        mask_ff <= pwdata[2:0];
      end
      if (wr_en && hit_prim) begin
        prim_mask_ff <= pwdata[1:0];
      end
    end
  end

  // apb answer; unmapped addresses give slverr and zero data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc && !hit_any;
      prdata_ff  <= 32'h0;
      if (acc && !pwrite) begin
        if (hit_stat) begin
          prdata_ff <= {29'h0, stat_ff};
        end else if (hit_mask) begin
          prdata_ff <= {29'h0, mask_ff};
        end else if (hit_prim) begin
          prdata_ff <= {30'h0, prim_mask_ff};
        end
      end
    end
  end

  assign pend = |(stat_ff & ~mask_ff);

  // interrupt outputs, registered so they are glitch-free
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ps_irq_ff <= 1'b0;
      hc_irq_ff <= 1'b0;
      uv_irq_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      ps_irq_ff <= pend;
      hc_irq_ff <= high_current_src && !prim_mask_ff[PSI_BIT_HC];
      uv_irq_ff <= undervoltage_src && !prim_mask_ff[PSI_BIT_UV];
      irq_ff    <= pend
                   || (high_current_src && !prim_mask_ff[PSI_BIT_HC])
                   || (undervoltage_src && !prim_mask_ff[PSI_BIT_UV]);
    end
  end

  assign pready                  = pready_ff;
  assign prdata                  = prdata_ff;
  assign pslverr                 = pslverr_ff;
  assign power_state_primary_irq = ps_irq_ff;
  assign high_current_irq        = hc_irq_ff;
  assign undervoltage_irq        = uv_irq_ff;
  assign irq                     = irq_ff;

  // checks on event capture, status clear, masks, irq outputs and apb answer
  property p_por_set;
    @(posedge sys_clk) disable iff (rst)
    (ev_ff[2] && !ev_prev_ff[2]) |=> stat_ff[2];
  endproperty
  a_por_set: assert property (p_por_set)
    else $error("por edge did not set status");

  property p_low_set;
    @(posedge sys_clk) disable iff (rst)
    $rose(ev_ff[1]) |=> stat_ff[1];
  endproperty
  a_low_set: assert property (p_low_set)
    else $error("low-state edge did not set status");

  property p_act_set;
    @(posedge sys_clk) disable iff (rst)
    enter_active_event ##1 !enter_active_event ##1 enter_active_event
      |=> ##1 stat_ff[0];
  endproperty
  a_act_set: assert property (p_act_set)
    else $error("active-state edge did not set status");

  property p_masked_poll;
    @(posedge sys_clk) disable iff (rst)
    (rise[2] && mask_ff[2]) |=> stat_ff[2];
  endproperty
  a_masked_poll: assert property (p_masked_poll)
    else $error("masked event not visible in status");

  property p_w1c;
    @(posedge sys_clk) disable iff (rst)
    (wr_stat && pwdata[0] && !rise[0]) |=> !stat_ff[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear status");

  property p_w0_keep;
    @(posedge sys_clk) disable iff (rst)
    (wr_stat && pwdata[2:0] == 3'h0 && rise == 3'h0)
      |=> stat_ff == $past(stat_ff);
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("write zero changed status");

  property p_mask_write;
    @(posedge sys_clk) disable iff (rst)
    (wr_en && hit_mask) |=> mask_ff == $past(pwdata[2:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask register did not take write");

  property p_mask_reset;
    @(posedge sys_clk)
    $fell(rst) |-> mask_ff == PSI_MASK_RST
                   && prim_mask_ff == PSI_PRIM_MASK_RST;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("masks not set after reset");

  property p_prim_mask;
    @(posedge sys_clk) disable iff (rst)
    prim_mask_ff[1] |=> !high_current_irq;
  endproperty
  a_prim_mask: assert property (p_prim_mask)
    else $error("masked high-current irq raised");

  property p_irq_level;
    @(posedge sys_clk) disable iff (rst)
    (pend |=> power_state_primary_irq) and
    (!pend |=> !power_state_primary_irq);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("primary irq does not follow pending");

  property p_all_masked;
    @(posedge sys_clk) disable iff (rst)
    (mask_ff == 3'h7) [*2] |-> !power_state_primary_irq;
  endproperty
  a_all_masked: assert property (p_all_masked)
    else $error("irq raised while fully masked");

  property p_answer;
    @(posedge sys_clk) disable iff (rst)
    (psel && penable && !pready) |=> pready;
  endproperty
  a_answer: assert property (p_answer) // apb one wait state
    else $error("apb access not answered in one cycle");

  // an unmasked rise reaches the primary irq two edges later
  property p_ps_source;
    @(posedge sys_clk) disable iff (rst)
    (|(rise & ~mask_ff) && !(wr_en && hit_mask))
      |=> ##1 power_state_primary_irq;
  endproperty
  a_ps_source: assert property (p_ps_source)
    else $error("unmasked event did not raise primary irq");

  property p_uv_mask;
    @(posedge sys_clk) disable iff (rst)
    prim_mask_ff[PSI_BIT_UV] |=> !undervoltage_irq;
  endproperty
  a_uv_mask: assert property (p_uv_mask)
    else $error("masked undervoltage irq raised");

  // pin rise to status, through both local samples
  property p_por_pin;
    @(posedge sys_clk) disable iff (rst)
    $rose(por_event) |=> ##1 stat_ff[PSI_BIT_POR];
  endproperty
  a_por_pin: assert property (p_por_pin)
    else $error("por pin rise not captured");

  // no status bit may drop unless a status write happens
  property p_stat_hold;
    @(posedge sys_clk) disable iff (rst)
    !wr_stat |=> (stat_ff & $past(stat_ff)) == $past(stat_ff);
  endproperty
  a_stat_hold: assert property (p_stat_hold)
    else $error("status bit dropped without a clear");

  property p_slverr;
    @(posedge sys_clk) disable iff (rst)
    (psel && penable && !pready && !hit_any) |=> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) // apb error answer
    else $error("unmapped access not flagged");

endmodule : psi_ctrl

// File: psi_pkg.sv
// psi_pkg: register indices, field positions and reset values for the
// power-state interrupt group. assumes a 32-bit apb with word registers.
package psi_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] PSI_STAT_IDX      = 16'h4012;
  localparam logic [15:0] PSI_MASK_IDX      = 16'h401a;
  localparam logic [15:0] PSI_PRIM_MASK_IDX = 16'h4020;
  // secondary event bit positions
  localparam int PSI_BIT_ACTIVE = 0;
  localparam int PSI_BIT_LOW    = 1;
  localparam int PSI_BIT_POR    = 2;
  localparam int PSI_NUM_EV     = 3;
  // primary mask bit positions
  localparam int PSI_BIT_UV = 0;
  localparam int PSI_BIT_HC = 1;
  // reset values: everything masked, status clear
  localparam logic [2:0] PSI_MASK_RST      = 3'h7;
  localparam logic [1:0] PSI_PRIM_MASK_RST = 2'h3;
  localparam logic [2:0] PSI_STAT_RST      = 3'h0;
endpackage : psi_pkg

// File: psi_host.sv
// psi_host: apb master standing in for host software.
// assumes one sys_clk and a slave that answers with pready.
`timescale 1ns/1ns
module psi_host (
  // clock
  input  wire logic        sys_clk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [17:0]      paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  task automatic acc(input logic w, input logic [17:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e, output logic t);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // bounded wait, no latency assumed
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    t = (n >= 16);
    // released lines must not look valid
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : acc
endmodule : psi_host

// File: tb.sv
// tb: random and corner tests of the power-state interrupt group.
// assumes psi_ctrl with default ADDR_W, driven by psi_host.
`timescale 1ns/1ns
module tb;
  import psi_pkg::*;
  localparam logic [17:0] A_ST = {PSI_STAT_IDX, 2'h0};
  localparam logic [17:0] A_MK = {PSI_MASK_IDX, 2'h0};
  localparam logic [17:0] A_PM = {PSI_PRIM_MASK_IDX, 2'h0};
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        hc, uv, ps_irq, hc_irq, uv_irq, irq, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ev, xs, xm, v;
  logic [31:0] seed = 32'hd0550fc5;
  int          checks = 0;
  int          n_fail = 0;

  psi_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .por_event(ev[2]), .enter_low_event(ev[1]),
    .enter_active_event(ev[0]), .high_current_src(hc),
    .undervoltage_src(uv), .power_state_primary_irq(ps_irq),
    .high_current_irq(hc_irq), .undervoltage_irq(uv_irq), .irq(irq));
  psi_host i_host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  // free-running 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // xorshift source, low bits only
  function automatic logic [2:0] rnd3();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[2:0];
  endfunction : rnd3

  // expected primary level from status and mask
  function automatic logic pend(input logic [2:0] s, m);
    return |(s & ~m);
  endfunction : pend

  task automatic cmp(input logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask : cmp

  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // one apb transfer; a hang ends the run
  task automatic bus(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    logic t;
    i_host.acc(w, a, d, rd, er, t);
    if (t) begin
      n_fail++;
      stop_test();
    end
  endtask : bus

  // main sequence: reset values, primaries, random events, then corners
  initial begin
    {rst, ev, hc, uv} = 6'h23;
    xs = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, A_MK, '0);
    cmp(rd, 32'h7);
    bus(1'b0, A_PM, '0);
    cmp(rd, 32'h3);
    cmp({28'h0, hc_irq, uv_irq, ps_irq, irq}, 32'h0);
    bus(1'b1, A_PM, 32'h1);
    repeat (3) @(posedge sys_clk);
    cmp({28'h0, hc_irq, uv_irq, ps_irq, irq}, 32'h9);
    // source low gates its irq; undervoltage passes unmasked
    hc <= 1'b0;
    bus(1'b1, A_PM, 32'h0);
    repeat (3) @(posedge sys_clk);
    cmp({28'h0, hc_irq, uv_irq, ps_irq, irq}, 32'h5);
    bus(1'b1, A_PM, 32'h3);
    bus(1'b0, 18'h10000, '0);
    cmp({31'h0, er}, 32'h1);
    repeat (24) begin
      xm = rnd3();
      bus(1'b1, A_MK, {29'h0, xm});
      v = rnd3();
      ev <= v;
      @(posedge sys_clk);
      ev <= '0;
      repeat (4) @(posedge sys_clk);
      xs = xs | v;
      bus(1'b0, A_ST, '0);
      cmp(rd, {29'h0, xs});
      cmp({30'h0, ps_irq, irq}, {30'h0, {2{pend(xs, xm)}}});
      v = rnd3();
      bus(1'b1, A_ST, {29'h0, v});
      xs = xs & ~v;
    end
    // corner: por held high through a mid-run reset counts once
    ev  <= 3'h4;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b1, A_ST, 32'h0);
    bus(1'b0, A_ST, '0);
    cmp(rd, 32'h4);
    bus(1'b0, A_MK, '0);
    cmp(rd, 32'h7);
    // held-high input must not set again after a clear
    bus(1'b1, A_ST, 32'h4);
    bus(1'b0, A_ST, '0);
    cmp(rd, 32'h0);
    // one low sample between two pulses gives a second rise
    ev <= 3'h1;
    @(posedge sys_clk);
    ev <= 3'h0;
    @(posedge sys_clk);
    ev <= 3'h1;
    @(posedge sys_clk);
    ev <= 3'h0;
    repeat (4) @(posedge sys_clk);
    bus(1'b0, A_ST, '0);
    cmp(rd, 32'h1);
    stop_test();
  end
endmodule : tb
